// file: rtl/fap_bank.sv
// register bank whose fields each enforce an access permission
// assumes a synchronous single-cycle register port, one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RULE1: hardware enforces each field's own permission
// RULE2: read-only returns value, writes are discarded
// RULE3: write-only accepts writes, reads undefined
// RULE4: read-write: unlimited writes and reads
// RULE5: write-once: first write per reset, reads undefined
// RULE6: read-write-once: readable, first write only
// RULE7: reserved bits read undefined; software writes zero
// RULE8: mixed register write applies per field
module fap_bank
  import fap_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic ack_o,
  output logic [31:0] rdata_o,
  // hardware status feeding read-only fields
  input wire logic [31:0] hw_status_i,
  // field values seen by the surrounding logic
  output logic [127:0] field_val_o,
  output logic [15:0] field_locked_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } fap_bstate_t;

  fap_bstate_t st_q, st_d;
  logic [7:0] field_rd [FAP_NUM_SLOTS];
  logic [31:0] rd_word;

  // ---------------------------------------------------------------
  // per-field instances
  // ---------------------------------------------------------------
  for (genvar g = 0; g < FAP_NUM_SLOTS; g++) begin : g_field
    localparam int unsigned REG = g / FAP_NUM_FIELDS;
    localparam int unsigned LANE = g % FAP_NUM_FIELDS;
    logic hit;
    // each lane decides alone, so one write can be partly taken
    assign hit = req_i && we_i && (addr_i == REG[1:0]); // RULE8 RULE1
    fap_field #(
      .PERM(FAP_PERM_MAP[g])
    ) u_field (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .wr_i(hit),
      .wdata_i(wdata_i[LANE*FAP_FIELD_W +: FAP_FIELD_W]),
      .hw_val_i(hw_status_i[LANE*FAP_FIELD_W +: FAP_FIELD_W]),
      .rdata_o(field_rd[g]),
      .value_o(field_val_o[g*FAP_FIELD_W +: FAP_FIELD_W]),
      .locked_o(field_locked_o[g])
    );
  end

  // ---------------------------------------------------------------
  // read mux and answer
  // ---------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    for (int l = 0; l < FAP_NUM_FIELDS; l++) begin
      rd_word[l*FAP_FIELD_W +: FAP_FIELD_W] = field_rd[{addr_i, 2'(l)}]; // RULE1
    end
    st_d.ack = req_i;
    st_d.rdata = (req_i && !we_i) ? rd_word : st_q.rdata;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '{ack: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_q <= st_d;
    end
  end

  assign ack_o = st_q.ack;
  assign rdata_o = st_q.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ack_timing_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i |=> ack_o)
    else $error("request not answered next cycle");
  ro_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE2
    (req_i && we_i && addr_i == FAP_IDX_STAT) |=> field_val_o[39:32] == $past(hw_status_i[7:0]))
    else $error("read-only field took a bus write");
  rsv_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE7
    (req_i && !we_i && addr_i == FAP_IDX_CFG) |=> rdata_o[31:24] == FAP_UNDEF_RD)
    else $error("reserved lane returned data");
  wo_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE3
    (req_i && !we_i && addr_i == FAP_IDX_KEY) |=> rdata_o == {4{FAP_UNDEF_RD}})
    else $error("write-only data leaked on read");
  mixed_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE8
    (req_i && we_i && addr_i == FAP_IDX_MIXED && field_locked_o[2])
      |=> field_val_o[7:0] == $past(wdata_i[7:0]) && $stable(field_val_o[23:16]))
    else $error("mixed write not applied per field");
  w1_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE5
    (req_i && !we_i && addr_i == FAP_IDX_MIXED) |=> rdata_o[23:16] == FAP_UNDEF_RD)
    else $error("write-once field readable");
  ack_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !req_i |=> !ack_o)
    else $error("answer given without a request");
  rdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !(req_i && !we_i) |=> $stable(rdata_o))
    else $error("read data moved without a read");
  rw1_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE6
    (req_i && !we_i && addr_i == FAP_IDX_MIXED) |=> rdata_o[31:24] == $past(field_val_o[31:24]))
    else $error("read-write-once field not readable");
  wo_take_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE3
    (req_i && we_i && addr_i == FAP_IDX_KEY) |=> field_val_o[71:64] == $past(wdata_i[7:0]))
    else $error("write-only field lost a write");
  // reserved lanes store nothing, whatever software writes there
  rsv_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE7
    field_val_o[63:48] == {2{FAP_FIELD_RST}} && field_val_o[127:120] == FAP_FIELD_RST)
    else $error("reserved lane holds data");

  lock_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    field_locked_o[3] ##1 (req_i && we_i && addr_i == FAP_IDX_MIXED));
  rd_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (req_i && we_i) ##1 (req_i && !we_i));
  ro_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    req_i && we_i && addr_i == FAP_IDX_STAT);
  key_lock_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    field_locked_o[10] && req_i && we_i && addr_i == FAP_IDX_KEY);
  cfg_rd_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    field_locked_o[13] && req_i && !we_i && addr_i == FAP_IDX_CFG);

endmodule : fap_bank
`default_nettype wire

// file: rtl/fap_field.sv
// one register field with its hardware-enforced access permission
// assumes writes and reads are single-cycle strobes from the parent
`timescale 1ns/10ps
`default_nettype none
module fap_field
  import fap_pkg::*;
#(
  parameter fap_perm_t PERM = FAP_RW
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // write side
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // hardware value for read-only fields
  input wire logic [7:0] hw_val_i,
  // read side
  output logic [7:0] rdata_o,
  output logic [7:0] value_o,
  output logic locked_o
);

  typedef struct packed {
    logic [7:0] val;
    logic locked;
  } fap_fstate_t;

  fap_fstate_t st_q, st_d;
  logic accept;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    accept = 1'b0;
    unique case (PERM)
      FAP_RO: st_d.val = hw_val_i; // RULE2
      FAP_WO, FAP_RW: accept = wr_i; // RULE3 RULE4
      FAP_WRITE_ONCE, FAP_READ_WRITE_ONCE: accept = wr_i && !st_q.locked; // RULE5 RULE6
      default: accept = 1'b0; // reserved bits hold nothing
    endcase
    if (accept) begin
      st_d.val = wdata_i;
      st_d.locked = 1'b1;
    end
  end

  // reset re-arms the once-only lock
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '{val: FAP_FIELD_RST, locked: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // read view
  // ---------------------------------------------------------------
  always_comb begin
    unique case (PERM)
      FAP_RO, FAP_RW, FAP_READ_WRITE_ONCE: rdata_o = st_q.val; // RULE2 RULE4 RULE6
      default: rdata_o = FAP_UNDEF_RD; // RULE3 RULE5 RULE7
    endcase
  end

  assign value_o = st_q.val;
  assign locked_o = st_q.locked;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  once_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE5
    ((PERM == FAP_WRITE_ONCE || PERM == FAP_READ_WRITE_ONCE) && st_q.locked)
      |=> $stable(st_q.val))
    else $error("once field changed after lock");
  once_take_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE6
    ((PERM == FAP_READ_WRITE_ONCE) && !st_q.locked && wr_i)
      |=> (st_q.val == $past(wdata_i)) && st_q.locked)
    else $error("first once write not taken");
  rw_take_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // RULE4
    ((PERM == FAP_RW) && wr_i) |=> rdata_o == $past(wdata_i))
    else $error("read-write field lost a write");

endmodule : fap_field
`default_nettype wire

// file: rtl/fap_pkg.sv
// package for the field access permission bank
// assumes one clock domain and a simple synchronous register port
package fap_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned FAP_DATA_W = 32;
  localparam int unsigned FAP_ADDR_W = 2;
  localparam int unsigned FAP_NUM_REGS = 4;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [1:0] FAP_IDX_MIXED = 2'h0;
  localparam logic [1:0] FAP_IDX_STAT = 2'h1;
  localparam logic [1:0] FAP_IDX_KEY = 2'h2;
  localparam logic [1:0] FAP_IDX_CFG = 2'h3;

  // ---------------------------------------------------------------
  // permission codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FAP_RSV = 3'h0,
    FAP_RO = 3'h1,
    FAP_WO = 3'h2,
    FAP_RW = 3'h3,
    FAP_WRITE_ONCE = 3'h4,
    FAP_READ_WRITE_ONCE = 3'h5
  } fap_perm_t;

  // ---------------------------------------------------------------
  // field layout: one 8-bit field per byte lane, per register
  // ---------------------------------------------------------------
  localparam int unsigned FAP_FIELD_W = 8;
  localparam int unsigned FAP_NUM_FIELDS = 4;
  localparam int unsigned FAP_NUM_SLOTS = FAP_NUM_REGS * FAP_NUM_FIELDS;

  // permission of slot (register * 4 + lane)
  localparam fap_perm_t FAP_PERM_MAP [FAP_NUM_SLOTS] = '{
    FAP_RW, FAP_RO, FAP_WRITE_ONCE, FAP_READ_WRITE_ONCE,
    FAP_RO, FAP_RO, FAP_RSV, FAP_RSV,
    FAP_WO, FAP_WO, FAP_WRITE_ONCE, FAP_WRITE_ONCE,
    FAP_RW, FAP_READ_WRITE_ONCE, FAP_RW, FAP_RSV
  };

  localparam logic [7:0] FAP_FIELD_RST = 8'h00;
  // value returned for unreadable or reserved lanes (arbitrary)
  localparam logic [7:0] FAP_UNDEF_RD = 8'h00;

endpackage : fap_pkg

// file: verification/fap_bank_bench.sv
// testbench for the field access permission bank
// assumes the register port and hand-over timing of the design notes
`timescale 1ns/10ps
`default_nettype none
module fap_bank_bench;
  import fap_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic we_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] hw_status_i = 32'h44332211;
  logic ack_o;
  logic [31:0] rdata_o;
  logic [127:0] field_val_o;
  logic [15:0] field_locked_o;
  int err_total = 0;
  int check_count = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  fap_bank u_fap_bank (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .we_i(we_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .ack_o(ack_o), .rdata_o(rdata_o),
    .hw_status_i(hw_status_i), .field_val_o(field_val_o), .field_locked_o(field_locked_o));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic do_reset();
    @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
  endtask : do_reset
  // one access; ack is due one cycle after the request edge
  task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(negedge ref_clk_i);
    req_i = 1'b1;
    we_i = w;
    addr_i = a;
    wdata_i = d;
    @(negedge ref_clk_i);
    req_i = 1'b0;
    we_i = 1'b0;
    chk({31'h0, ack_o}, 32'h1);
  endtask : acc
  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rdata_o, exp);
  endtask : rd
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_mixed();
    chk({16'h0, field_locked_o}, 32'h0);
    acc(1'b1, FAP_IDX_MIXED, 32'haabbccdd);
    chk({16'h0, field_locked_o}, 32'h000d);
    rd(FAP_IDX_MIXED, 32'haa0022dd);
    chk({24'h0, field_val_o[23:16]}, 32'hbb);
    acc(1'b1, FAP_IDX_MIXED, 32'h11223344);
    rd(FAP_IDX_MIXED, 32'haa002244);
    rd(FAP_IDX_MIXED, 32'haa002244);
    chk({24'h0, field_val_o[23:16]}, 32'hbb);
  endtask : t_mixed
  task automatic t_write_side();
    acc(1'b1, FAP_IDX_KEY, 32'h01020304);
    chk(field_val_o[95:64], 32'h01020304);
    acc(1'b1, FAP_IDX_KEY, 32'h05060708);
    chk(field_val_o[95:64], 32'h01020708);
    rd(FAP_IDX_KEY, 32'h0);
  endtask : t_write_side
  // read-only lanes track the hardware value, reserved lanes read the fill
  task automatic t_status();
    acc(1'b1, FAP_IDX_STAT, 32'h0);
    rd(FAP_IDX_STAT, 32'h00002211);
    hw_status_i = 32'h4433aa55;
    rd(FAP_IDX_STAT, 32'h0000aa55);
    acc(1'b1, FAP_IDX_CFG, 32'h00ccbbee);
    acc(1'b1, FAP_IDX_CFG, 32'h00112233);
    rd(FAP_IDX_CFG, 32'h0011bb33);
  endtask : t_status
  // a fresh reset must re-arm every once-only lane
  task automatic t_rearm();
    do_reset();
    chk({16'h0, field_locked_o}, 32'h0);
    acc(1'b1, FAP_IDX_MIXED, 32'h99887766);
    chk(field_val_o[31:0], 32'h9988aa66);
    rd(FAP_IDX_MIXED, 32'h9900aa66);
  endtask : t_rearm
  // ---------------------------------------------------------------
  // sequence, watchdog and verdict
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  initial begin
    do_reset();
    t_mixed();
    t_write_side();
    t_status();
    t_rearm();
    close_out();
  end
  // whole run is well under 100 cycles; 2000 leaves ample margin
  initial begin
    #20000;
    err_total++;
    close_out();
  end
endmodule : fap_bank_bench
`default_nettype wire
